/* File: rtl/irf_regs.vh */
// constants of the interrupt request flag block
`ifndef IRF_REGS_VH
`define IRF_REGS_VH
`define IRF_NSRC       10
`define IRF_SRC_EXTA   0
`define IRF_SRC_UART2  1
`define IRF_SRC_CNTA   2
`define IRF_SRC_TWI    3
`define IRF_SRC_EXTB   4
`define IRF_SRC_RSVD   5
`define IRF_SRC_CNTB   6
`define IRF_SRC_USB    7
`define IRF_SRC_UART1  8
`define IRF_SRC_CNTC   9
`define IRF_USB_NEV    6
`define IRF_USB_EP0TX  0
`define IRF_USB_EP0RX  1
`define IRF_USB_EP12TX 2
`define IRF_USB_SUSP   3
`define IRF_USB_RESUM  4
`define IRF_USB_EOP    5
`define IRF_FLAGS_RST  10'h000
`define IRF_USB_RST    6'h00
`define IRF_CNTA_SPLIT 2'h3
`endif

/* File: rtl/irf_request_flags.v */
// interrupt request flags, enables, priority and pending selection
//
// What this block does
// - nine request sources and one reserved slot: two lines, three counters, two serial, two-wire, usb
// - external line a level or edge per its trigger select, flag raises request
// - external line b likewise with its own trigger select and flag
// - edge-triggered external flags cleared by hardware on vectoring
// - counter a and b overflow sets flags, except counter a split mode 3
// - counter a and b overflow flags cleared by hardware when serviced
// - counter c overflow flag set by hardware, cleared only by software
// - counter c external trigger sets external flag when enabled
// - two-wire request bit raises interrupt, cleared by hardware
// - converter done may take over the external line b request
// - usb request on ep0 tx/rx, ep1/2 tx, suspend, resume, end-of-packet
// - usb flags stay set until software clears them
// - per-source enable bits, global enable suppresses all
// - one priority bit per source, high preempts low
`timescale 1ns/1ps
`default_nettype none
`include "irf_regs.vh"

// two-flop synchroniser with a third stage kept for edge detection
module irf_sync2 #(
	parameter [0:0] RST = 1'b0
) (
	// clock and reset
	input  wire mclk,
	input  wire srst,
	// asynchronous input and its synchronised copies
	input  wire din,
	output wire dout,
	output wire dout_prev
);

	reg  [2:0] stage_reg;

	// reset value is the idle level of the input, so no false edge follows reset
	always @(posedge mclk) begin
		if (srst) begin
			stage_reg <= {3{RST}};
		end else begin
			stage_reg <= {stage_reg[1:0], din};
		end
	end

	// the first stage may be metastable and is never read outside
	assign dout      = stage_reg[1];
	assign dout_prev = stage_reg[2];

endmodule // irf_sync2

module irf_request_flags #(
	parameter NSRC = `IRF_NSRC
) (
	// clock and reset
	input  wire             mclk,
	input  wire             srst,
	// external pins
	input  wire             ext_line_a_n,
	input  wire             ext_line_b_n,
	// trigger configuration
	input  wire             ext_a_trigger_select,
	input  wire             ext_b_trigger_select,
	input  wire             adc_takeover,
	input  wire             adc_done,
	// peripheral events, one-cycle pulses; counter a mode, counter c trigger and its enable are levels
	input  wire             counter_a_ovf,
	input  wire [1:0]       counter_a_mode,
	input  wire             counter_b_ovf,
	input  wire             counter_c_ovf,
	input  wire             counter_c_ext_trigger,
	input  wire             counter_c_ext_enable,
	input  wire             twowire_request_bit,
	input  wire             uart1_request,
	input  wire             uart2_request,
	input  wire [5:0]       usb_event,
	// software clears, one-cycle pulses
	input  wire             counter_c_ovf_clr,
	input  wire             counter_c_ext_clr,
	input  wire [5:0]       usb_flag_clr,
	// enable and priority
	input  wire             global_irq_enable,
	input  wire [NSRC-1:0]  src_enable,
	input  wire [NSRC-1:0]  src_priority,
	// core vectoring
	input  wire             vector_ack,
	input  wire [3:0]       vector_src,
	// status and request
	output reg  [NSRC-1:0]  flags_reg,
	output reg  [5:0]       usb_flags_reg,
	output reg              counter_c_overflow_flag,
	output reg              counter_c_ext_flag,
	output wire [NSRC-1:0]  pending,
	output wire             irq_valid,
	output wire [3:0]       irq_src,
	output wire             irq_high
);

	wire            sync_a;
	wire            sync_b;
	wire            sync_t;
	wire            prev_a;
	wire            prev_b;
	wire            prev_t;
	reg  [NSRC-1:0] flags_next;
	reg  [NSRC-1:0] set_v;
	reg  [NSRC-1:0] hwclr_v;
	reg  [3:0]      sel_hi;
	reg  [3:0]      sel_lo;
	reg             any_hi;
	reg             any_lo;
	integer         i;

	wire            lvl_a   = ~sync_a;
	wire            lvl_b   = ~sync_b;
	wire            fall_a  = prev_a & ~sync_a;
	wire            fall_b  = prev_b & ~sync_b;
	wire            rise_t  = ~prev_t & sync_t;
	wire [NSRC-1:0] one_hot = {{(NSRC-1){1'b0}}, 1'b1};
	// an index beyond the last source shifts out and clears nothing
	wire [NSRC-1:0] ack_v   = vector_ack ? (one_hot << vector_src) : {NSRC{1'b0}};

	// pins pass two flops before use; pins idle high, the trigger idles low
	irf_sync2 #(
		.RST (1'b1)
	) u_sync_a (
		.mclk      (mclk),
		.srst      (srst),
		.din       (ext_line_a_n),
		.dout      (sync_a),
		.dout_prev (prev_a)
	);

	irf_sync2 #(
		.RST (1'b1)
	) u_sync_b (
		.mclk      (mclk),
		.srst      (srst),
		.din       (ext_line_b_n),
		.dout      (sync_b),
		.dout_prev (prev_b)
	);

	irf_sync2 #(
		.RST (1'b0)
	) u_sync_t (
		.mclk      (mclk),
		.srst      (srst),
		.din       (counter_c_ext_trigger),
		.dout      (sync_t),
		.dout_prev (prev_t)
	);

	always @* begin
		set_v = {NSRC{1'b0}};
		hwclr_v = {NSRC{1'b0}};
		set_v[`IRF_SRC_EXTA] = ext_a_trigger_select ? fall_a : lvl_a;
		set_v[`IRF_SRC_EXTB] = adc_takeover ? adc_done :
			(ext_b_trigger_select ? fall_b : lvl_b);
		set_v[`IRF_SRC_CNTA] = counter_a_ovf & (counter_a_mode != `IRF_CNTA_SPLIT);
		set_v[`IRF_SRC_CNTB] = counter_b_ovf;
		set_v[`IRF_SRC_TWI] = twowire_request_bit;
		set_v[`IRF_SRC_UART1] = uart1_request;
		set_v[`IRF_SRC_UART2] = uart2_request;
		// edge flags cleared on vector
		// level flags also clear on vector, but a line still held keeps them set, since set wins
		hwclr_v[`IRF_SRC_EXTA] = ack_v[`IRF_SRC_EXTA];
		hwclr_v[`IRF_SRC_EXTB] = ack_v[`IRF_SRC_EXTB];
		hwclr_v[`IRF_SRC_CNTA] = ack_v[`IRF_SRC_CNTA];
		hwclr_v[`IRF_SRC_CNTB] = ack_v[`IRF_SRC_CNTB];
		hwclr_v[`IRF_SRC_TWI] = ack_v[`IRF_SRC_TWI];
		hwclr_v[`IRF_SRC_UART1] = ack_v[`IRF_SRC_UART1];
		hwclr_v[`IRF_SRC_UART2] = ack_v[`IRF_SRC_UART2];
		// set wins over clear
		flags_next = (flags_reg & ~hwclr_v) | set_v;
		// usb summary and counter c follow software-cleared flags
		flags_next[`IRF_SRC_USB] = |usb_flags_reg;
		flags_next[`IRF_SRC_CNTC] = counter_c_overflow_flag | counter_c_ext_flag;
		flags_next[`IRF_SRC_RSVD] = 1'b0;
	end

	always @(posedge mclk) begin
		if (srst) begin
			flags_reg <= `IRF_FLAGS_RST;
			usb_flags_reg <= `IRF_USB_RST;
			counter_c_overflow_flag <= 1'b0;
			counter_c_ext_flag <= 1'b0;
		end else begin
			flags_reg <= flags_next;
			usb_flags_reg <= (usb_flags_reg & ~usb_flag_clr) | usb_event;
			counter_c_overflow_flag <= (counter_c_overflow_flag & ~counter_c_ovf_clr)
				| counter_c_ovf;
			counter_c_ext_flag <= (counter_c_ext_flag & ~counter_c_ext_clr)
				| (rise_t & counter_c_ext_enable);
		end
	end

	assign pending = flags_reg & src_enable & {NSRC{global_irq_enable}};

	// high level first, then fixed polling order, lowest index wins
	always @* begin
		sel_hi = 4'h0;
		sel_lo = 4'h0;
		any_hi = 1'b0;
		any_lo = 1'b0;
		for (i = NSRC - 1; i >= 0; i = i - 1) begin
			if (pending[i] & src_priority[i]) begin
				sel_hi = i[3:0];
				any_hi = 1'b1;
			end
			if (pending[i] & ~src_priority[i]) begin
				sel_lo = i[3:0];
				any_lo = 1'b1;
			end
		end
	end

	assign irq_valid = any_hi | any_lo;
	assign irq_high = any_hi;
	assign irq_src = any_hi ? sel_hi : sel_lo;

endmodule // irf_request_flags
`default_nettype wire

/* File: dv/irf_chk.sv */
// checker of the interrupt request flags, bound to the design top
`timescale 1ns/1ps
`default_nettype none
module irf_chk #(parameter NSRC = 10) (
	input wire logic mclk, srst, counter_b_ovf, counter_c_ovf_clr, global_irq_enable,
	input wire logic vector_ack, counter_c_overflow_flag, irq_valid, irq_high,
	input wire logic [1:0] counter_a_mode,
	input wire logic [3:0] vector_src, irq_src,
	input wire logic [5:0] usb_event, usb_flags_reg,
	input wire logic [NSRC-1:0] src_enable, src_priority, flags_reg, pending
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	a_b_set: assert property (counter_b_ovf |=> flags_reg[6])
		else $error("counter b overflow lost");
	a_a_split: assert property (counter_a_mode == 2'h3 && !flags_reg[2] |=> !flags_reg[2])
		else $error("counter a flag set in split mode");
	a_b_clear: assert property (vector_ack && vector_src == 4'h6 && !counter_b_ovf |=> !flags_reg[6])
		else $error("counter b flag kept after vector");
	a_c_hold: assert property (counter_c_overflow_flag && !counter_c_ovf_clr |=> counter_c_overflow_flag)
		else $error("counter c flag dropped");
	a_usb_set: assert property (|usb_event |=> (usb_flags_reg & $past(usb_event)) == $past(usb_event))
		else $error("usb event not flagged");
	a_pend_gate: assert property (irq_valid == (global_irq_enable && (flags_reg & src_enable) != 0))
		else $error("pending gating wrong");
	a_src_pend: assert property (irq_valid |-> pending[irq_src])
		else $error("granted source not pending");
	a_global_off: assert property (!global_irq_enable |-> !irq_valid)
		else $error("request with global enable off");
	a_high_cause: assert property (irq_high |-> irq_valid && (pending & src_priority) != 0)
		else $error("high level without high source");
endmodule // irf_chk
bind irf_request_flags irf_chk #(.NSRC(NSRC)) u_chk (.*);
`default_nettype wire

/* File: dv/irf_core_model.sv */
// core model that vectors to the granted source
`timescale 1ns/1ps
`default_nettype none
module irf_core_model (
	input wire logic mclk, srst, ack_en, irq_valid,
	input wire logic [3:0] irq_src,
	output logic vector_ack = 1'h0,
	output logic [3:0] vector_src = 4'h0
);
	// idle index is inverted so a stale value never helps the design
	always @(posedge mclk) begin
		vector_ack <= #1 ack_en && irq_valid && !vector_ack && !srst;
		vector_src <= #1 (ack_en && irq_valid && !vector_ack) ? irq_src : ~irq_src;
	end
endmodule // irf_core_model
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench of the interrupt request flags
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {logic [1:0] md; logic [5:0] usb, ev; logic [9:0] ex;} irf_row_t;
	logic mclk = 1'h0, srst = 1'h1, ext_line_a_n = 1'h1, ext_a_trigger_select = 1'h0;
	logic global_irq_enable = 1'h1, counter_c_ext_trigger = 1'h0, counter_c_ext_enable = 1'h0;
	logic counter_c_ovf_clr = 1'h0, ack_en = 1'h0, counter_a_ovf, counter_b_ovf, counter_c_ovf;
	logic twowire_request_bit, uart1_request, uart2_request, vector_ack, irq_valid, irq_high;
	logic counter_c_overflow_flag, counter_c_ext_flag;
	logic [1:0] counter_a_mode = 2'h0;
	logic [3:0] vector_src, irq_src;
	logic [5:0] ev = 6'h00, usb_event = 6'h00, usb_flag_clr = 6'h00, usb_flags_reg;
	logic [9:0] src_enable = 10'h3ff, src_priority = 10'h000, flags_reg, pending;
	logic ext_line_b_n = 1'h1, ext_b_trigger_select = 1'h0, adc_takeover = 1'h0;
	logic adc_done = 1'h0, counter_c_ext_clr = 1'h0;
	int fails = 0, check_count = 0;
	irf_row_t rows [8] = '{'{2'h0, 6'h00, 6'h01, 10'h004}, '{2'h3, 6'h00, 6'h01, 10'h000},
		'{2'h0, 6'h00, 6'h02, 10'h040}, '{2'h0, 6'h00, 6'h04, 10'h200},
		'{2'h0, 6'h00, 6'h08, 10'h008}, '{2'h0, 6'h00, 6'h10, 10'h100},
		'{2'h0, 6'h00, 6'h20, 10'h002}, '{2'h0, 6'h10, 6'h00, 10'h080}};
	assign {uart2_request, uart1_request, twowire_request_bit} = ev[5:3];
	assign {counter_c_ovf, counter_b_ovf, counter_a_ovf} = ev[2:0];
	irf_request_flags dut (.*);
	irf_core_model u_core (.*);
	always #4 mclk = ~mclk;
	task automatic cyc(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pulse(logic [5:0] p, logic [5:0] u);
		ev = p;
		usb_event = u;
		cyc(1);
		ev = 6'h00;
		usb_event = 6'h00;
		cyc(3);
	endtask
	task automatic end_of_test;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#20000;
		fails++;
		end_of_test;
	end
	initial begin
		cyc(3);
		foreach (rows[i]) begin
			srst = 1'h1;
			cyc(1);
			srst = 1'h0;
			counter_a_mode = rows[i].md;
			pulse(rows[i].ev, rows[i].usb);
			chk("flags", rows[i].ex, flags_reg);
			chk("pending", rows[i].ex, pending);
		end
		ack_en = 1'h1;
		pulse(6'h06, 6'h3f);
		cyc(8);
		chk("flags", 10'h280, flags_reg);
		chk("usb", {4'h0, 6'h3f}, {4'h0, usb_flags_reg});
		counter_c_ovf_clr = 1'h1;
		usb_flag_clr = 6'h3f;
		cyc(1);
		counter_c_ovf_clr = 1'h0;
		usb_flag_clr = 6'h00;
		cyc(2);
		chk("flags", 10'h000, flags_reg);
		src_enable = 10'h3bf;
		pulse(6'h02, 6'h00);
		chk("pending", 10'h000, pending);
		src_enable = 10'h3ff;
		global_irq_enable = 1'h0;
		cyc(2);
		chk("irq", 10'h040, {flags_reg[9:1], irq_valid});
		global_irq_enable = 1'h1;
		cyc(4);
		chk("flags", 10'h000, flags_reg);
		ack_en = 1'h0;
		src_priority = 10'h200;
		pulse(6'h06, 6'h00);
		chk("grant", 10'h209, {irq_high, 5'h00, irq_src});
		src_priority = 10'h000;
		cyc(1);
		chk("grant", 10'h006, {irq_high, 5'h00, irq_src});
		srst = 1'h1;
		cyc(1);
		srst = 1'h0;
		ext_line_a_n = 1'h0;
		cyc(5);
		chk("flags", 10'h001, flags_reg);
		ext_line_a_n = 1'h1;
		ack_en = 1'h1;
		cyc(8);
		chk("flags", 10'h000, flags_reg);
		ack_en = 1'h0;
		ext_a_trigger_select = 1'h1;
		ext_line_a_n = 1'h0;
		cyc(5);
		chk("flags", 10'h001, flags_reg);
		ack_en = 1'h1;
		counter_c_ext_enable = 1'h1;
		counter_c_ext_trigger = 1'h1;
		cyc(6);
		chk("flags", 10'h200, flags_reg);
		chk("ext", 10'h001, {9'h000, counter_c_ext_flag});
		counter_c_ext_clr = 1'h1;
		cyc(1);
		counter_c_ext_clr = 1'h0;
		cyc(2);
		chk("flags", 10'h000, flags_reg);
		// overflow and software clear in one cycle: the set wins
		ev = 6'h04;
		counter_c_ovf_clr = 1'h1;
		cyc(1);
		ev = 6'h00;
		counter_c_ovf_clr = 1'h0;
		cyc(1);
		chk("ovf", 10'h001, {9'h000, counter_c_overflow_flag});
		ack_en = 1'h0;
		ext_line_a_n = 1'h1;
		counter_c_ext_trigger = 1'h0;
		srst = 1'h1;
		cyc(1);
		srst = 1'h0;
		ext_line_b_n = 1'h0;
		cyc(5);
		chk("flags", 10'h010, flags_reg);
		ext_line_b_n = 1'h1;
		ack_en = 1'h1;
		cyc(8);
		chk("flags", 10'h000, flags_reg);
		ack_en = 1'h0;
		ext_b_trigger_select = 1'h1;
		ext_line_b_n = 1'h0;
		cyc(5);
		chk("flags", 10'h010, flags_reg);
		ack_en = 1'h1;
		cyc(4);
		chk("flags", 10'h000, flags_reg);
		ack_en = 1'h0;
		adc_takeover = 1'h1;
		ext_line_b_n = 1'h1;
		cyc(4);
		ext_line_b_n = 1'h0;
		cyc(4);
		chk("flags", 10'h000, flags_reg);
		adc_done = 1'h1;
		cyc(1);
		adc_done = 1'h0;
		cyc(1);
		chk("flags", 10'h010, flags_reg);
		chk("grant", 10'h004, {irq_high, 5'h00, irq_src});
		end_of_test;
	end
endmodule // tb_top
`default_nettype wire
